// ---- pkg/csx_pkg.sv ----
// package for the alu, shift, exchange and block operation datapath
// assumes one operation at a time, issued over apb
// Contract
// - and immediate; h set, n and c cleared, s z pv from result
// - subtract immediate; h bit 4 borrow, pv overflow, n set, c borrow
// - or immediate; h, n and c cleared, s z pv from result
// - subtract with borrow takes carry too; flags as subtract
// - xor immediate; h, n and c cleared, s z pv from result
// - immediate operations take seven t states
// - rotate left circular; bit 7 to bit 0 and carry
// - rotate right circular; bit 0 to bit 7 and carry
// - rotate left through carry; carry to bit 0, bit 7 to carry
// - rotate right through carry; carry to bit 7, bit 0 to carry
// - shift left arithmetic; bit 7 to carry, s z pv from result
// - shift right arithmetic; bit 0 to carry, s z pv from result
// - shift right logical; bit 0 to carry, sign cleared
// - pointer-pair rotate or shift takes fifteen t states
// - indexed shift picks index by select bit; twenty-three t states
// - digit rotates move nibbles with memory, carry kept; eighteen t states
// - pointer and alternate pair swaps take four t states, flags kept
// - accumulator and flags swap with alternates in four t states
// - stack exchange swaps register with stack bytes; nineteen or twenty-three
// - block move copies, steps pointers, counts down; pv on nonzero count
// - block compare subtracts unstored; z on equal, pv on nonzero count
package csx_pkg;
    // ----
    // register map, byte addresses
    // ----
    localparam logic [11:0] CSX_CTRL_OFF = 12'h000;
    localparam logic [11:0] CSX_STAT_OFF = 12'h004;
    localparam logic [11:0] CSX_AF_OFF = 12'h008;
    localparam logic [11:0] CSX_BCDE_OFF = 12'h00c;
    localparam logic [11:0] CSX_HLSP_OFF = 12'h010;
    localparam logic [11:0] CSX_IDX_OFF = 12'h014;
    localparam logic [11:0] CSX_ALT_AF_OFF = 12'h018;
    localparam logic [11:0] CSX_ALT_BCDE_OFF = 12'h01c;
    localparam logic [11:0] CSX_ALT_HL_OFF = 12'h020;
    localparam logic [11:0] CSX_MEM_OFF = 12'h024;
    // ctrl fields
    localparam int CSX_OP_LSB = 0;
    localparam int CSX_OP_W = 5;
    localparam int CSX_IMM_LSB = 8;
    localparam int CSX_XSEL_BIT = 16;
    localparam int CSX_DISP_LSB = 24;
    localparam int CSX_GO_BIT = 31;
    // flag bit positions
    localparam int CSX_F_C = 0;
    localparam int CSX_F_N = 1;
    localparam int CSX_F_PV = 2;
    localparam int CSX_F_H = 4;
    localparam int CSX_F_Z = 6;
    localparam int CSX_F_S = 7;
    localparam logic [15:0] CSX_REG_RST = 16'h0000;
    // t state counts
    localparam logic [4:0] CSX_T_IMM = 5'd7;
    localparam logic [4:0] CSX_T_SH_PTR = 5'd15;
    localparam logic [4:0] CSX_T_SH_IDX = 5'd23;
    localparam logic [4:0] CSX_T_DIGIT = 5'd18;
    localparam logic [4:0] CSX_T_SWAP = 5'd4;
    localparam logic [4:0] CSX_T_STK_PTR = 5'd19;
    localparam logic [4:0] CSX_T_STK_IDX = 5'd23;
    localparam logic [4:0] CSX_T_BLOCK = 5'd16;

    typedef enum logic [4:0] {
        CSX_AND, CSX_SUB, CSX_OR, CSX_SUB_WITH_BORROW, CSX_XOR,
        CSX_ROTATE_LEFT_CIRCULAR, CSX_ROTATE_RIGHT_CIRCULAR,
        CSX_ROTATE_LEFT_THROUGH_CARRY, CSX_ROTATE_RIGHT_THROUGH_CARRY,
        CSX_SHIFT_LEFT_ARITH, CSX_SHIFT_RIGHT_ARITH, CSX_SHIFT_RIGHT_LOGICAL,
        CSX_DIGIT_ROTATE_LEFT, CSX_DIGIT_ROTATE_RIGHT,
        CSX_SWAP_POINTERS, CSX_SWAP_ALT_PAIRS, CSX_SWAP_ALT_AF,
        CSX_STACK_SWAP_PTR, CSX_STACK_SWAP_IDX,
        CSX_BLOCK_MOVE_INCREMENT, CSX_BLOCK_MOVE_DECREMENT,
        CSX_BLOCK_COMPARE_INCREMENT, CSX_BLOCK_COMPARE_DECREMENT,
        CSX_SHIFT_INDEXED_BASE
    } csx_op_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [15:0] byte_counter_pair;
        logic [15:0] second_pointer_pair;
        logic [15:0] memory_pointer_pair;
        logic [15:0] stack_pointer;
        logic [15:0] index_first;
        logic [15:0] index_second;
    } csx_regs_t;
endpackage

// ---- hdl/csx_core.sv ----
// datapath for immediate logic and subtract, memory rotates and shifts, digit
// rotates, exchanges and single block move and compare, with a small memory model
// assumes an apb master; one operation runs at a time, one t state per pclk
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module csx_core
    import csx_pkg::*;
#(
    parameter int MEM_AW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy
);
    // ----
    // helpers
    // ----
    function automatic logic [7:0] szp(input logic [7:0] r, input logic [7:0] f);
        logic [7:0] o;
        o = f;
        o[CSX_F_S] = r[7];
        o[CSX_F_Z] = (r == 8'h00);
        o[CSX_F_PV] = ~^r;
        return o;
    endfunction

    // a - b - cin, returns {flags, result}
    function automatic logic [15:0] subf(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin, input logic [7:0] f);
        logic [8:0] d;
        logic [4:0] lo;
        logic [7:0] o;
        d = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        o = szp(d[7:0], f);
        o[CSX_F_H] = lo[4];
        o[CSX_F_PV] = (a[7] ^ b[7]) & (a[7] ^ d[7]);
        o[CSX_F_N] = 1'b1;
        o[CSX_F_C] = d[8];
        return {o, d[7:0]};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] o;
        o = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                o[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return o;
    endfunction

    // memory window: hit flag above the byte index
    function automatic logic [MEM_AW:0] mem_slot(input logic [11:0] a);
        logic [11:0] d;
        d = a - CSX_MEM_OFF;
        return {a >= CSX_MEM_OFF && d[11:MEM_AW+2] == '0, d[MEM_AW+1:2]};
    endfunction

    // ----
    // state
    // ----
    csx_regs_t r, next_r;
    logic [7:0] alt_acc, alt_flags, next_alt_acc, next_alt_flags;
    logic [15:0] alt_bc, alt_de, alt_hl, next_alt_bc, next_alt_de, next_alt_hl;
    logic [7:0] mem [2**MEM_AW];
    logic [7:0] next_mem [2**MEM_AW];
    logic [31:0] ctrl, next_ctrl;
    logic [4:0] tcnt, next_tcnt;
    logic busy_q, next_busy;
    logic [31:0] next_prdata;

    logic access;
    logic wr;
    logic [MEM_AW-1:0] ea, sp_a, sp_b, hl_a, de_a;
    logic [15:0] idx, ea16;
    csx_op_t op;

    logic [MEM_AW:0] ms;
    assign ms = mem_slot(paddr);
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign op = csx_op_t'(ctrl[CSX_OP_LSB +: CSX_OP_W]);
    assign idx = ctrl[CSX_XSEL_BIT] ? r.index_second : r.index_first;
    assign ea16 = idx + {{8{ctrl[CSX_DISP_LSB+7]}}, ctrl[CSX_DISP_LSB +: 8]};
    assign hl_a = r.memory_pointer_pair[MEM_AW-1:0];
    assign de_a = r.second_pointer_pair[MEM_AW-1:0];
    assign sp_a = r.stack_pointer[MEM_AW-1:0];
    assign sp_b = MEM_AW'(r.stack_pointer + 16'h0001);
    assign ea = ctrl[CSX_XSEL_BIT + 1] ? ea16[MEM_AW-1:0] : hl_a;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign busy = busy_q;

    // ----
    // operation cycle count
    // ----
    function automatic logic [4:0] tlen(input csx_op_t o, input logic indexed);
        case (o)
            CSX_AND, CSX_SUB, CSX_OR, CSX_SUB_WITH_BORROW, CSX_XOR: return CSX_T_IMM;
            CSX_DIGIT_ROTATE_LEFT, CSX_DIGIT_ROTATE_RIGHT: return CSX_T_DIGIT;
            CSX_SWAP_POINTERS, CSX_SWAP_ALT_PAIRS, CSX_SWAP_ALT_AF: return CSX_T_SWAP;
            CSX_STACK_SWAP_PTR: return CSX_T_STK_PTR;
            CSX_STACK_SWAP_IDX: return CSX_T_STK_IDX;
            CSX_BLOCK_MOVE_INCREMENT, CSX_BLOCK_MOVE_DECREMENT,
            CSX_BLOCK_COMPARE_INCREMENT, CSX_BLOCK_COMPARE_DECREMENT: return CSX_T_BLOCK;
            default: return indexed ? CSX_T_SH_IDX : CSX_T_SH_PTR;
        endcase
    endfunction

    // ----
    // execute and register access
    // ----
    always_comb begin
        logic [7:0] a, f, m, res, nf;
        logic [15:0] sr, bcm1, step;
        logic [31:0] w;
        a = r.acc;
        f = r.flags;
        m = mem[ea];
        res = 8'h00;
        nf = f;
        sr = 16'h0000;
        w = 32'h0;
        bcm1 = r.byte_counter_pair - 16'h0001;
        step = 16'h0001;
        next_r = r;
        next_alt_acc = alt_acc;
        next_alt_flags = alt_flags;
        next_alt_bc = alt_bc;
        next_alt_de = alt_de;
        next_alt_hl = alt_hl;
        next_mem = mem;
        next_ctrl = ctrl;
        next_tcnt = tcnt;
        next_busy = busy_q;
        next_prdata = prdata;
        if (busy_q && tcnt != 5'd1) begin
            next_tcnt = tcnt - 5'd1;
        end else if (busy_q) begin
            next_busy = 1'b0;
            next_tcnt = 5'd0;
            next_ctrl[CSX_GO_BIT] = 1'b0;
            case (op)
                CSX_AND: begin
                    res = a & ctrl[CSX_IMM_LSB +: 8];
                    nf = szp(res, 8'h00);
                    nf[CSX_F_H] = 1'b1;
                    next_r.acc = res;
                    next_r.flags = nf;
                end
                CSX_OR, CSX_XOR: begin
                    res = (op == CSX_OR) ? (a | ctrl[CSX_IMM_LSB +: 8])
                                         : (a ^ ctrl[CSX_IMM_LSB +: 8]);
                    next_r.acc = res;
                    next_r.flags = szp(res, 8'h00);
                end
                CSX_SUB, CSX_SUB_WITH_BORROW: begin
                    {nf, res} = subf(a, ctrl[CSX_IMM_LSB +: 8],
                                     (op == CSX_SUB_WITH_BORROW) & f[CSX_F_C], f);
                    next_r.acc = res;
                    next_r.flags = nf;
                end
                CSX_DIGIT_ROTATE_LEFT, CSX_DIGIT_ROTATE_RIGHT: begin
                    if (op == CSX_DIGIT_ROTATE_LEFT) begin
                        res = {a[7:4], m[7:4]};
                        next_mem[hl_a] = {m[3:0], a[3:0]};
                    end else begin
                        res = {a[7:4], m[3:0]};
                        next_mem[hl_a] = {a[3:0], m[7:4]};
                    end
                    nf = szp(res, f);
                    nf[CSX_F_H] = 1'b0;
                    nf[CSX_F_N] = 1'b0; // carry kept
                    next_r.acc = res;
                    next_r.flags = nf;
                end
                CSX_SWAP_POINTERS: begin
                    next_r.second_pointer_pair = r.memory_pointer_pair;
                    next_r.memory_pointer_pair = r.second_pointer_pair;
                end
                CSX_SWAP_ALT_PAIRS: begin
                    next_r.byte_counter_pair = alt_bc;
                    next_r.second_pointer_pair = alt_de;
                    next_r.memory_pointer_pair = alt_hl;
                    next_alt_bc = r.byte_counter_pair;
                    next_alt_de = r.second_pointer_pair;
                    next_alt_hl = r.memory_pointer_pair;
                end
                CSX_SWAP_ALT_AF: begin
                    next_r.acc = alt_acc;
                    next_r.flags = alt_flags;
                    next_alt_acc = r.acc;
                    next_alt_flags = r.flags;
                end
                CSX_STACK_SWAP_PTR, CSX_STACK_SWAP_IDX: begin
                    sr = (op == CSX_STACK_SWAP_PTR) ? r.memory_pointer_pair : idx;
                    next_mem[sp_a] = sr[7:0];
                    next_mem[sp_b] = sr[15:8];
                    sr = {mem[sp_b], mem[sp_a]};
                    if (op == CSX_STACK_SWAP_PTR) begin
                        next_r.memory_pointer_pair = sr;
                    end else if (ctrl[CSX_XSEL_BIT]) begin
                        next_r.index_second = sr;
                    end else begin
                        next_r.index_first = sr;
                    end
                end
                CSX_BLOCK_MOVE_INCREMENT, CSX_BLOCK_MOVE_DECREMENT: begin
                    if (op == CSX_BLOCK_MOVE_DECREMENT) begin
                        step = 16'hffff;
                    end
                    next_mem[de_a] = mem[hl_a];
                    next_r.second_pointer_pair = r.second_pointer_pair + step;
                    next_r.memory_pointer_pair = r.memory_pointer_pair + step;
                    next_r.byte_counter_pair = bcm1;
                    nf[CSX_F_H] = 1'b0;
                    nf[CSX_F_N] = 1'b0;
                    nf[CSX_F_PV] = (bcm1 != 16'h0000);
                    next_r.flags = nf;
                end
                CSX_BLOCK_COMPARE_INCREMENT, CSX_BLOCK_COMPARE_DECREMENT: begin
                    if (op == CSX_BLOCK_COMPARE_DECREMENT) begin
                        step = 16'hffff;
                    end
                    {nf, res} = subf(a, mem[hl_a], 1'b0, f);
                    nf[CSX_F_C] = f[CSX_F_C];
                    nf[CSX_F_PV] = (bcm1 != 16'h0000);
                    next_r.memory_pointer_pair = r.memory_pointer_pair + step;
                    next_r.byte_counter_pair = bcm1;
                    next_r.flags = nf;
                end
                default: begin
                    case (op)
                        CSX_ROTATE_LEFT_CIRCULAR: res = {m[6:0], m[7]};
                        CSX_ROTATE_RIGHT_CIRCULAR: res = {m[0], m[7:1]};
                        CSX_ROTATE_LEFT_THROUGH_CARRY: res = {m[6:0], f[CSX_F_C]};
                        CSX_ROTATE_RIGHT_THROUGH_CARRY: res = {f[CSX_F_C], m[7:1]};
                        CSX_SHIFT_LEFT_ARITH: res = {m[6:0], 1'b0};
                        CSX_SHIFT_RIGHT_ARITH: res = {m[7], m[7:1]};
                        default: res = {1'b0, m[7:1]};
                    endcase
                    nf = szp(res, 8'h00);
                    case (op)
                        CSX_ROTATE_LEFT_CIRCULAR, CSX_ROTATE_LEFT_THROUGH_CARRY,
                        CSX_SHIFT_LEFT_ARITH: nf[CSX_F_C] = m[7];
                        default: nf[CSX_F_C] = m[0];
                    endcase
                    if (op <= CSX_SHIFT_RIGHT_LOGICAL) begin
                        next_mem[ea] = res;
                        next_r.flags = nf;
                    end
                end
            endcase
        end
        // register bus
        // loaded in setup so read data stands at the ready edge
        if (psel && !penable && !pwrite) begin
            case (paddr)
                CSX_CTRL_OFF: next_prdata = ctrl;
                CSX_STAT_OFF: next_prdata = {26'h0, busy_q, tcnt};
                CSX_AF_OFF: next_prdata = {16'h0, r.acc, r.flags};
                CSX_BCDE_OFF: next_prdata = {r.byte_counter_pair, r.second_pointer_pair};
                CSX_HLSP_OFF: next_prdata = {r.memory_pointer_pair, r.stack_pointer};
                CSX_IDX_OFF: next_prdata = {r.index_first, r.index_second};
                CSX_ALT_AF_OFF: next_prdata = {16'h0, alt_acc, alt_flags};
                CSX_ALT_BCDE_OFF: next_prdata = {alt_bc, alt_de};
                CSX_ALT_HL_OFF: next_prdata = {16'h0, alt_hl};
                default: begin
                    if (ms[MEM_AW]) begin
                        next_prdata = {24'h0, mem[ms[MEM_AW-1:0]]};
                    end else begin
                        next_prdata = 32'h0;
                    end
                end
            endcase
        end
        if (wr && !busy_q) begin
            case (paddr)
                CSX_CTRL_OFF: begin
                    w = merge(ctrl, pwdata, pstrb);
                    next_ctrl = w;
                    if (w[CSX_GO_BIT]) begin
                        next_busy = 1'b1;
                        next_tcnt = tlen(csx_op_t'(w[CSX_OP_W-1:0]), w[CSX_XSEL_BIT + 1]);
                    end
                end
                CSX_AF_OFF: {next_r.acc, next_r.flags} = 16'(merge({16'h0, r.acc, r.flags},
                                                                  pwdata, pstrb));
                CSX_BCDE_OFF: {next_r.byte_counter_pair, next_r.second_pointer_pair} =
                    merge({r.byte_counter_pair, r.second_pointer_pair}, pwdata, pstrb);
                CSX_HLSP_OFF: {next_r.memory_pointer_pair, next_r.stack_pointer} =
                    merge({r.memory_pointer_pair, r.stack_pointer}, pwdata, pstrb);
                CSX_IDX_OFF: {next_r.index_first, next_r.index_second} =
                    merge({r.index_first, r.index_second}, pwdata, pstrb);
                default: begin
                    if (ms[MEM_AW] && pstrb[0]) begin
                        next_mem[ms[MEM_AW-1:0]] = pwdata[7:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            alt_acc <= 8'h00;
            alt_flags <= 8'h00;
            alt_bc <= CSX_REG_RST;
            alt_de <= CSX_REG_RST;
            alt_hl <= CSX_REG_RST;
            ctrl <= 32'h0;
            tcnt <= 5'd0;
            busy_q <= 1'b0;
            prdata <= 32'h0;
            for (int i = 0; i < 2**MEM_AW; i++) begin
                mem[i] <= 8'h00;
            end
        end else begin
            r <= next_r;
            alt_acc <= next_alt_acc;
            alt_flags <= next_alt_flags;
            alt_bc <= next_alt_bc;
            alt_de <= next_alt_de;
            alt_hl <= next_alt_hl;
            ctrl <= next_ctrl;
            tcnt <= next_tcnt;
            busy_q <= next_busy;
            prdata <= next_prdata;
            mem <= next_mem;
        end
    end
endmodule

// ---- bench/csx_core_assertions.sv ----
// checker for the datapath: bus answer and operation lengths
// assumes it is bound to csx_core and sees its ports only
`timescale 1ns/10ps
module csx_core_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy
);
    // ----
    // helper: operation latched at start, busy cycles counted
    // ----
    logic go, ix, next_ix;
    logic [4:0] op, next_op;
    logic [5:0] cnt, next_cnt;
    assign go = psel && penable && pwrite && paddr == 12'h000 && pwdata[31] && !busy;
    always_comb begin
        next_op = go ? pwdata[4:0] : op;
        next_ix = go ? pwdata[17] : ix;
        next_cnt = go ? 6'h00 : (busy ? cnt + 6'h01 : cnt);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= 5'h00;
            ix <= 1'b0;
            cnt <= 6'h00;
        end else begin
            op <= next_op;
            ix <= next_ix;
            cnt <= next_cnt;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // assertions
    // ----
    chk_ready_high: assert property (pready)
        else $error("ready low");
    chk_no_error: assert property (!pslverr)
        else $error("error response");
    chk_imm_len: assert property (go && pwdata[4:0] <= 5'd4 |=> busy [*7] ##1 !busy)
        else $error("immediate op length");
    chk_swap_len: assert property (
        go && pwdata[4:0] inside {[5'd14:5'd16]} |=> busy [*4] ##1 !busy)
        else $error("swap length");
    chk_shift_len: assert property (
        $fell(busy) && op inside {[5'd5:5'd11]} && !ix |-> cnt == 6'd15)
        else $error("shift length");
    chk_index_len: assert property (
        $fell(busy) && op inside {[5'd5:5'd11]} && ix |-> cnt == 6'd23)
        else $error("indexed shift length");
    chk_digit_len: assert property (
        $fell(busy) && op inside {5'd12, 5'd13} |-> cnt == 6'd18)
        else $error("digit rotate length");
    chk_stack_len: assert property (
        $fell(busy) && op inside {5'd17, 5'd18} |-> cnt == (op == 5'd17 ? 6'd19 : 6'd23))
        else $error("stack swap length");
    chk_block_len: assert property (
        $fell(busy) && op inside {[5'd19:5'd22]} |-> cnt == 6'd16)
        else $error("block op length");
endmodule

bind csx_core csx_core_checker u_chk (.*);

// ---- bench/csx_apb_model.sv ----
// decoder side model: issues register transfers as an apb master
// assumes read data stands in the access phase and is taken at the ready edge
`timescale 1ns/10ps
module csx_apb_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    logic hung = 1'b0;
    initial {psel, penable, pwrite, pstrb} = 7'h0f;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) hung = 1'b1;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ---- bench/test_cpu_alu_shift_exchange_block_ops.sv ----
// self-checking bench for the datapath, one task per scenario
// assumes the apb model drives the bus and the checker is bound in
`timescale 1ns/10ps
module test_cpu_alu_shift_exchange_block_ops import csx_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    int fail_count = 0;
    int checks_done = 0;
    always #2.5 pclk = ~pclk;
    csx_core dut (.*);
    csx_apb_model m (.*);
    // ----
    // helpers
    // ----
    task automatic give_verdict;
        if (m.hung) fail_count++;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [11:0] ma(input int i);
        return CSX_MEM_OFF + 12'(4 * i);
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        m.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a);
        m.xfer(1'b0, a, 32'h0, q);
    endtask
    // starts an operation with displacement -1 and waits for idle
    task automatic run(input logic [4:0] op, input logic [7:0] imm, input logic [1:0] ix);
        int n;
        n = 0;
        wr(CSX_CTRL_OFF, {8'hff, 6'h00, ix, imm, 3'h0, op});
        @(posedge pclk);
        while (busy !== 1'b0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100) begin
            fail_count++;
            give_verdict();
        end
    endtask
    // result and flags s z - h - pv n c
    function automatic logic [15:0] alu(input logic [4:0] op, input logic [7:0] a,
            input logic [7:0] n, input logic c);
        logic [8:0] r;
        logic sb, h, v;
        sb = op == 5'd1 || op == 5'd3;
        case (op)
            5'd0: r = {1'b0, a & n};
            5'd2: r = {1'b0, a | n};
            5'd4: r = {1'b0, a ^ n};
            5'd5: r = {a[7], a[6:0], a[7]};
            5'd6: r = {a[0], a[0], a[7:1]};
            5'd7: r = {a, c};
            5'd8: r = {a[0], c, a[7:1]};
            5'd9: r = {a, 1'b0};
            5'd10: r = {a[0], a[7], a[7:1]};
            5'd11: r = {a[0], 1'b0, a[7:1]};
            default: r = {1'b0, a} - {1'b0, n} - 9'(op == 5'd3 && c);
        endcase
        h = op == 5'd0 || (sb && {1'b0, a[3:0]} < {1'b0, n[3:0]} + 5'(op == 5'd3 && c));
        v = sb ? (a[7] != n[7]) && (r[7] != a[7]) : ~^r[7:0];
        return {r[7:0], r[7], r[7:0] == 8'h0, 1'b0, h, 1'b0, v, sb, r[8]};
    endfunction
    // ----
    // scenarios
    // ----
    task automatic t_imm;
        logic [7:0] av [2];
        logic [7:0] nv [2];
        av = '{8'h3c, 8'h80};
        nv = '{8'h4f, 8'h01};
        for (int j = 0; j < 2; j++) begin
            for (int op = 0; op < 5; op++) begin
                wr(CSX_AF_OFF, {16'h0, av[j], 8'h01});
                run(5'(op), nv[j], 2'b00);
                rd(CSX_AF_OFF);
                check(q & 32'hffd7, {16'h0, alu(5'(op), av[j], nv[j], 1'b1)});
            end
        end
    endtask
    task automatic t_shift;
        logic [7:0] a;
        logic [15:0] ex;
        wr(CSX_HLSP_OFF, 32'h0003_0000);
        for (int j = 0; j < 2; j++) begin
            for (int op = 5; op < 12; op++) begin
                a = j ? 8'h42 : 8'h81;
                ex = alu(5'(op), a, 8'h0, j[0]);
                wr(ma(3), {24'h0, a});
                wr(CSX_AF_OFF, {31'h0, j[0]});
                run(5'(op), 8'h0, 2'b00);
                rd(ma(3));
                check(q & 32'hff, {24'h0, ex[15:8]});
                rd(CSX_AF_OFF);
                check(q & 32'hffd7, {24'h0, ex[7:0]});
            end
        end
    endtask
    task automatic t_index;
        wr(CSX_IDX_OFF, 32'h0003_0009);
        for (int s = 0; s < 2; s++) begin
            wr(ma(2), 32'h81);
            wr(ma(8), 32'h81);
            run(5'd5, 8'h0, {1'b1, s[0]});
            rd(s ? ma(8) : ma(2));
            check(q & 32'hff, 32'h03);
            rd(s ? ma(2) : ma(8));
            check(q & 32'hff, 32'h81);
        end
    endtask
    task automatic t_digit;
        wr(CSX_HLSP_OFF, 32'h0003_0000);
        for (int d = 0; d < 2; d++) begin
            wr(ma(3), 32'h34);
            wr(CSX_AF_OFF, 32'h1201);
            run(5'(12 + d), 8'h0, 2'b00);
            rd(ma(3));
            check(q & 32'hff, d ? 32'h23 : 32'h42);
            rd(CSX_AF_OFF);
            check(q & 32'hffd7, d ? 32'h1405 : 32'h1301);
        end
    endtask
    task automatic t_swap;
        wr(CSX_BCDE_OFF, 32'h1111_2222);
        wr(CSX_HLSP_OFF, 32'h3333_0000);
        wr(CSX_AF_OFF, 32'h55aa);
        run(5'd14, 8'h0, 2'b00);
        rd(CSX_BCDE_OFF);
        check(q, 32'h1111_3333);
        rd(CSX_HLSP_OFF);
        check(q, 32'h2222_0000);
        run(5'd15, 8'h0, 2'b00);
        rd(CSX_ALT_BCDE_OFF);
        check(q, 32'h1111_3333);
        rd(CSX_ALT_HL_OFF);
        check(q, 32'h2222);
        rd(CSX_BCDE_OFF);
        check(q, 32'h0);
        rd(CSX_AF_OFF);
        check(q, 32'h55aa);
        run(5'd16, 8'h0, 2'b00);
        rd(CSX_ALT_AF_OFF);
        check(q, 32'h55aa);
        rd(CSX_AF_OFF);
        check(q, 32'h0);
    endtask
    task automatic t_stack;
        wr(CSX_HLSP_OFF, 32'habcd_0006);
        wr(ma(6), 32'h11);
        wr(ma(7), 32'h22);
        run(5'd17, 8'h0, 2'b00);
        rd(CSX_HLSP_OFF);
        check(q, 32'h2211_0006);
        rd(ma(6));
        check(q & 32'hff, 32'hcd);
        rd(ma(7));
        check(q & 32'hff, 32'hab);
    endtask
    task automatic t_block;
        wr(CSX_BCDE_OFF, 32'h0001_0005);
        wr(CSX_HLSP_OFF, 32'h0002_0000);
        wr(ma(2), 32'h5a);
        wr(CSX_AF_OFF, 32'h5a16);
        run(5'd19, 8'h0, 2'b00);
        rd(ma(5));
        check(q & 32'hff, 32'h5a);
        rd(CSX_BCDE_OFF);
        check(q, 32'h0000_0006);
        rd(CSX_HLSP_OFF);
        check(q, 32'h0003_0000);
        rd(CSX_AF_OFF);
        check(q & 32'hffd7, 32'h5a00);
        wr(CSX_BCDE_OFF, 32'h0002_0006);
        wr(CSX_HLSP_OFF, 32'h0002_0000);
        wr(CSX_AF_OFF, 32'h5a01);
        run(5'd22, 8'h0, 2'b00);
        rd(CSX_AF_OFF);
        check(q & 32'hffd7, 32'h5a47);
        rd(CSX_HLSP_OFF);
        check(q, 32'h0001_0000);
        rd(CSX_BCDE_OFF);
        check(q, 32'h0001_0006);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_imm();
        t_shift();
        t_index();
        t_digit();
        t_swap();
        t_stack();
        t_block();
        // an unmapped place reads as zero
        rd(12'hff0);
        check(q, 32'h0);
        give_verdict();
    end
endmodule
